/* File: hdl/alu_ops_core.sv */
// accumulator alu instruction executor with file registers behind an ahb-lite slave
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module alu_ops_core #(
    parameter int FILE_DEPTH = alu_ops_pkg::FILE_DEPTH
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        alu_ops_pkg::exec_t ex;
        logic [13:0] instr;
        logic [7:0] acc;
        logic carry;
        logic nibble;
        logic zero;
        logic bad_op;
        logic [7:0] oper;
        logic dp_act;
        logic dp_write;
        logic [11:0] dp_addr;
        logic dp_fresh;
        logic [31:0] rdata;
        logic [FILE_DEPTH-1:0][7:0] files;
    } state_t;

    state_t r_reg;
    state_t r_next;

    logic [1:0] phase;
    logic last;
    alu_ops_pkg::op_t op;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_nib;
    logic alu_z;
    logic commit;
    logic stable;
    logic addr_take;
    logic [6:0] idx;
    logic dest_file;

    cycle_phase #(
        .PHASES(alu_ops_pkg::PHASES)
    ) u_phase (
        .clk(CLK),
        .rstn(RSTN),
        .phase(phase),
        .last(last)
    );

    assign op = alu_ops_pkg::decode_op(r_reg.instr);
    assign idx = r_reg.instr[6:0];
    assign dest_file = r_reg.instr[7];

    // immediate forms take the literal, file forms the operand read at start
    assign alu_b = (op == alu_ops_pkg::OP_IMM_SUM || op == alu_ops_pkg::OP_IMM_MASK)
        ? r_reg.instr[7:0] : r_reg.oper;

    alu_unit u_alu (
        .op(op),
        .a(r_reg.acc),
        .b(alu_b),
        .bitsel(r_reg.instr[9:7]),
        .result(alu_res),
        .carry(alu_c),
        .nibble(alu_nib),
        .zero(alu_z)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus helpers

    function automatic logic [31:0] read_word(input state_t s, input logic [11:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == alu_ops_pkg::ADDR_INSTR) begin
            d = {18'h00000, s.instr};
        end else if (a == alu_ops_pkg::ADDR_ACC) begin
            d = {24'h000000, s.acc};
        end else if (a == alu_ops_pkg::ADDR_FLAGS) begin
            d[alu_ops_pkg::FLAG_CARRY] = s.carry;
            d[alu_ops_pkg::FLAG_NIBBLE] = s.nibble;
            d[alu_ops_pkg::FLAG_ZERO] = s.zero;
        end else if (a == alu_ops_pkg::ADDR_STATE) begin
            d[alu_ops_pkg::STATE_BUSY] = (s.ex != alu_ops_pkg::EX_IDLE);
            d[alu_ops_pkg::STATE_BADOP] = s.bad_op;
        end else if (is_file(a)) begin
            d = {24'h000000, s.files[file_index(a)]};
        end
        return d;
    endfunction

    function automatic logic is_file(input logic [11:0] a);
        return a[11:9] == alu_ops_pkg::ADDR_FILE_BASE[11:9] && a[1:0] == 2'h0;
    endfunction

    function automatic logic [6:0] file_index(input logic [11:0] a);
        return a[8:2];
    endfunction

    // bus writes may only change the core state while no instruction is queued or running
    assign stable = (r_reg.ex == alu_ops_pkg::EX_IDLE);
    assign commit = (r_reg.ex == alu_ops_pkg::EX_RUN) && last;
    assign addr_take = HSEL && HTRANS[1] && HREADY;

    // reads wait one cycle, longer while an instruction is queued or running, so the word reflects settled state
    always_comb begin
        if (!r_reg.dp_act) begin
            HREADYOUT = 1'b1;
        end else if (r_reg.dp_write) begin
            HREADYOUT = stable;
        end else begin
            HREADYOUT = r_reg.dp_fresh;
        end
    end

    assign HRDATA = r_reg.rdata;
    assign HRESP = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;

        // data phase: refresh read word, apply write when released
        if (r_reg.dp_act) begin
            r_next.rdata = read_word(r_reg, r_reg.dp_addr);
            r_next.dp_fresh = stable;
            if (r_reg.dp_write && stable) begin
                if (r_reg.dp_addr == alu_ops_pkg::ADDR_INSTR) begin
                    r_next.instr = HWDATA[13:0];
                    r_next.bad_op = 1'b0;
                    r_next.ex = alu_ops_pkg::EX_WAIT;
                end else if (r_reg.dp_addr == alu_ops_pkg::ADDR_ACC) begin
                    r_next.acc = HWDATA[7:0];
                end else if (r_reg.dp_addr == alu_ops_pkg::ADDR_FLAGS) begin
                    r_next.carry = HWDATA[alu_ops_pkg::FLAG_CARRY];
                    r_next.nibble = HWDATA[alu_ops_pkg::FLAG_NIBBLE];
                    r_next.zero = HWDATA[alu_ops_pkg::FLAG_ZERO];
                end else if (is_file(r_reg.dp_addr)) begin
                    r_next.files[file_index(r_reg.dp_addr)] = HWDATA[7:0];
                end
            end
        end

        // address phase
        if (HREADYOUT) begin
            r_next.dp_act = addr_take;
            r_next.dp_write = HWRITE;
            r_next.dp_addr = HADDR[11:0];
            r_next.dp_fresh = 1'b0;
        end

        // execution sequence, aligned to the instruction cycle
        case (r_reg.ex)
            alu_ops_pkg::EX_IDLE: begin
                r_next.ex = r_next.ex;
            end
            alu_ops_pkg::EX_WAIT: begin
                if (phase == alu_ops_pkg::PHASE_START) begin
                    r_next.ex = alu_ops_pkg::EX_RUN;
                    r_next.oper = r_reg.files[idx];
                end
            end
            alu_ops_pkg::EX_RUN: begin
                if (last) begin
                    r_next.ex = alu_ops_pkg::EX_IDLE;
                end
            end
            default: begin
                r_next.ex = alu_ops_pkg::EX_IDLE;
            end
        endcase

        if (commit) begin
            case (op)
                alu_ops_pkg::OP_IMM_SUM: begin
                    r_next.acc = alu_res;
                    r_next.carry = alu_c;
                    r_next.nibble = alu_nib;
                    r_next.zero = alu_z;
                end
                alu_ops_pkg::OP_IMM_MASK: begin
                    r_next.acc = alu_res;
                    r_next.zero = alu_z;
                end
                alu_ops_pkg::OP_FILE_SUM: begin
                    r_next.carry = alu_c;
                    r_next.nibble = alu_nib;
                    r_next.zero = alu_z;
                    if (dest_file) begin
                        r_next.files[idx] = alu_res;
                    end else begin
                        r_next.acc = alu_res;
                    end
                end
                alu_ops_pkg::OP_FILE_MASK: begin
                    r_next.zero = alu_z;
                    if (dest_file) begin
                        r_next.files[idx] = alu_res;
                    end else begin
                        r_next.acc = alu_res;
                    end
                end
                // full byte written back, flags untouched
                alu_ops_pkg::OP_BIT_RESET: begin
                    r_next.files[idx] = alu_res;
                end
                default: begin
                    r_next.bad_op = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r_reg <= '0;
            r_reg.ex <= alu_ops_pkg::EX_IDLE;
            r_reg.instr <= alu_ops_pkg::INSTR_RST;
            r_reg.acc <= alu_ops_pkg::ACC_RST;
            r_reg.files <= {FILE_DEPTH{alu_ops_pkg::FILE_RST}};
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    logic [7:0] sel_file;
    assign sel_file = r_reg.files[idx];

    AST_CYCLE_FOUR: assert property (
        r_reg.ex == alu_ops_pkg::EX_WAIT && phase == alu_ops_pkg::PHASE_START
        |=> (r_reg.ex == alu_ops_pkg::EX_RUN) [*3] ##1 r_reg.ex == alu_ops_pkg::EX_IDLE
    ) else $error("instruction did not finish in four periods");

    AST_IMM_SUM: assert property (
        commit && op == alu_ops_pkg::OP_IMM_SUM
        |=> r_reg.acc == 8'($past(r_reg.acc) + $past(r_reg.instr[7:0]))
    ) else $error("immediate sum wrong");

    AST_IMM_MASK: assert property (
        commit && op == alu_ops_pkg::OP_IMM_MASK
        |=> r_reg.acc == ($past(r_reg.acc) & $past(r_reg.instr[7:0])) && r_reg.zero == (r_reg.acc == 8'h00)
    ) else $error("immediate mask wrong");

    AST_DEST_FILE: assert property (
        commit && dest_file && (op == alu_ops_pkg::OP_FILE_SUM || op == alu_ops_pkg::OP_FILE_MASK)
        |=> $stable(r_reg.acc) && sel_file == $past(alu_res)
    ) else $error("file target not honoured");

    AST_FILE_MASK: assert property (
        r_reg.ex == alu_ops_pkg::EX_WAIT && phase == alu_ops_pkg::PHASE_START
        && op == alu_ops_pkg::OP_FILE_MASK && !dest_file
        |=> ##3 r_reg.acc == ($past(r_reg.acc, 4) & $past(sel_file, 4))
    ) else $error("file mask wrong");

    AST_FILE_SUM_FLAGS: assert property (
        commit && op == alu_ops_pkg::OP_FILE_SUM
        |=> r_reg.carry == $past(alu_c) && r_reg.nibble == $past(alu_nib) && r_reg.zero == $past(alu_z)
    ) else $error("file sum flags wrong");

    AST_BIT_RESET: assert property (
        r_reg.ex == alu_ops_pkg::EX_WAIT && phase == alu_ops_pkg::PHASE_START && op == alu_ops_pkg::OP_BIT_RESET
        |=> ##3 sel_file == ($past(sel_file, 4) & ~(8'h01 << r_reg.instr[9:7])) && $stable(r_reg.zero)
    ) else $error("bit reset wrong");

    COV_IMM_SUM: cover property (commit && op == alu_ops_pkg::OP_IMM_SUM && alu_c);
    COV_FILE_DEST: cover property (commit && op == alu_ops_pkg::OP_FILE_MASK && dest_file);
    COV_BIT_RESET: cover property (commit && op == alu_ops_pkg::OP_BIT_RESET);
    COV_READ_STALL: cover property (r_reg.dp_act && !r_reg.dp_write && !stable);
endmodule

/* File: pkg/alu_ops_pkg.sv */
// shared constants, types and decode for the accumulator alu instruction block
package alu_ops_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing: clk is the oscillator, one instruction cycle is four periods
    localparam int PHASES = 4;
    localparam int PHASE_W = 2;
    localparam logic [1:0] PHASE_START = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [11:0] ADDR_INSTR = 12'h000;
    localparam logic [11:0] ADDR_ACC = 12'h004;
    localparam logic [11:0] ADDR_FLAGS = 12'h008;
    localparam logic [11:0] ADDR_STATE = 12'h00c;
    localparam logic [11:0] ADDR_FILE_BASE = 12'h200;
    localparam int FILE_DEPTH = 128;

    // field positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO = 2;
    localparam int STATE_BUSY = 0;
    localparam int STATE_BADOP = 1;

    // values after reset
    localparam logic [13:0] INSTR_RST = 14'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // operations and execution states
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_IMM_SUM = 3'b001,
        OP_IMM_MASK = 3'b010,
        OP_FILE_SUM = 3'b011,
        OP_FILE_MASK = 3'b100,
        OP_BIT_RESET = 3'b101
    } op_t;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_WAIT = 2'b01,
        EX_RUN = 2'b10
    } exec_t;

    function automatic op_t decode_op(input logic [13:0] w);
        op_t op;
        op = OP_NONE;
        if (w[13:9] == 5'h1f) begin
            op = OP_IMM_SUM;
        end else if (w[13:8] == 6'h39) begin
            op = OP_IMM_MASK;
        end else if (w[13:8] == 6'h07) begin
            op = OP_FILE_SUM;
        end else if (w[13:8] == 6'h05) begin
            op = OP_FILE_MASK;
        end else if (w[13:10] == 4'h4) begin
            op = OP_BIT_RESET;
        end
        return op;
    endfunction

endpackage

/* File: hdl/cycle_phase.sv */
// divider that splits the oscillator into the four phases of an instruction cycle
`timescale 1ns/10ps
module cycle_phase #(
    parameter int PHASES = alu_ops_pkg::PHASES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic [alu_ops_pkg::PHASE_W-1:0] phase,
    output logic last
);
    typedef struct packed {
        logic [alu_ops_pkg::PHASE_W-1:0] cnt;
    } st_t;

    st_t st_reg;
    st_t st_next;

    // four oscillator periods per instruction cycle
    // phase divider
    always_comb begin
        st_next = st_reg;
        st_next.cnt = st_reg.cnt + 2'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase = st_reg.cnt;
    assign last = (st_reg.cnt == alu_ops_pkg::PHASE_LAST);
endmodule

/* File: hdl/alu_unit.sv */
// combinational adder, masker and bit clearer shared by all operations
`timescale 1ns/10ps
module alu_unit (
    input alu_ops_pkg::op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bitsel,
    output logic [7:0] result,
    output logic carry,
    output logic nibble,
    output logic zero
);
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        sum = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        result = a;
        case (op)
            alu_ops_pkg::OP_IMM_SUM, alu_ops_pkg::OP_FILE_SUM: begin
                result = sum[7:0];
            end
            alu_ops_pkg::OP_IMM_MASK, alu_ops_pkg::OP_FILE_MASK: begin
                result = a & b;
            end
            alu_ops_pkg::OP_BIT_RESET: begin
                result = b & ~(8'h01 << bitsel);
            end
            default: begin
                result = a;
            end
        endcase
        carry = sum[8];
        nibble = low[4];
        zero = (result == 8'h00);
    end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the accumulator alu instruction block, driven over ahb-lite
`timescale 1ns/10ps
module tb;
    ////////////////////////////////////////////////////////////////////////
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] rd;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 49279;
    int m_acc = 0;
    int m_c = 0;
    int m_nib = 0;
    int m_z = 0;
    int m_file[128];

    always #2.5 clk = ~clk;

    // one slave on the bus, so its own hreadyout is the bus hready
    alu_ops_core DUT (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait so a stuck slave is reported instead of hanging the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, hreadyout}, 32'h1);
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~wd;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    function automatic logic [11:0] faddr(input int f);
        return alu_ops_pkg::ADDR_FILE_BASE + 12'(f * 4);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one instruction on random operands; iteration 0 forces carry and zero on the sums, zero on the masks
    task automatic run_op(input int op, input int it);
        int a, v, f, d, b, s, r, fl;
        logic [13:0] w;
        realtime t0;
        a = $random(seed) & 255;
        v = $random(seed) & 255;
        f = $random(seed) & 127;
        d = $random(seed) & 1;
        b = $random(seed) & 7;
        fl = $random(seed) & 7;
        if (it == 0) begin
            a = 255;
            v = (op == 1 || op == 3) ? 0 : 1;
        end
        wr32(alu_ops_pkg::ADDR_ACC, 32'(a));
        wr32(alu_ops_pkg::ADDR_FLAGS, 32'(fl));
        wr32(faddr(f), 32'(v));
        m_acc = a;
        m_c = fl & 1;
        m_nib = (fl >> 1) & 1;
        m_z = (fl >> 2) & 1;
        m_file[f] = v;
        case (op)
            0: w = {5'h1f, 1'(d), 8'(v)};
            1: w = {6'h39, 8'(v)};
            2: w = {6'h07, 1'(d), 7'(f)};
            3: w = {6'h05, 1'(d), 7'(f)};
            default: w = {4'h4, 3'(b), 7'(f)};
        endcase
        s = a + v;
        r = (op == 0 || op == 2) ? (s & 255) : (op == 4 ? (v & ~(1 << b) & 255) : (a & v));
        if (op == 0 || op == 2) begin
            m_c = (s > 255);
            m_nib = ((a % 16) + (v % 16)) > 15;
        end
        if (op != 4) begin
            m_z = (r == 0);
        end
        if (op == 4 || (op >= 2 && d == 1)) begin
            m_file[f] = r;
        end else begin
            m_acc = r;
        end
        wr32(alu_ops_pkg::ADDR_INSTR, 32'(w));
        t0 = $realtime;
        rd_chk(alu_ops_pkg::ADDR_ACC, 32'(m_acc));
        // one phase-aligned instruction cycle plus the read wait: 6 to 9 clocks
        check(32'(($realtime - t0) >= 30.0 && ($realtime - t0) <= 45.0), 32'h1);
        rd_chk(alu_ops_pkg::ADDR_FLAGS, 32'(m_z * 4 + m_nib * 2 + m_c));
        rd_chk(faddr(f), 32'(m_file[f]));
        rd_chk(alu_ops_pkg::ADDR_STATE, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(alu_ops_pkg::ADDR_ACC, 32'h0);
        rd_chk(alu_ops_pkg::ADDR_FLAGS, 32'h0);
        rd_chk(alu_ops_pkg::ADDR_STATE, 32'h0);
        rd_chk(faddr(0), 32'h0);
        rd_chk(faddr(127), 32'h0);
        $display("test reset values done");
        for (int op = 0; op < 5; op++) begin
            for (int it = 0; it < 8; it++) begin
                run_op(op, it);
            end
            $display("test op %0d done", op);
        end
        // an opcode outside the group leaves the accumulator alone
        wr32(alu_ops_pkg::ADDR_INSTR, 32'h3a55);
        rd_chk(alu_ops_pkg::ADDR_STATE, 32'h2);
        rd_chk(alu_ops_pkg::ADDR_ACC, 32'(m_acc));
        wr32(alu_ops_pkg::ADDR_STATE, 32'h0);
        rd_chk(alu_ops_pkg::ADDR_STATE, 32'h2);
        run_op(1, 1);
        $display("test bad opcode done");
        wr32(12'h100, 32'h5a);
        rd_chk(12'h100, 32'h0);
        wr32(alu_ops_pkg::ADDR_ACC, 32'hffff_ff3c);
        rd_chk(alu_ops_pkg::ADDR_ACC, 32'h3c);
        $display("test map edges done");
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(alu_ops_pkg::ADDR_ACC, 32'h0);
        rd_chk(faddr(5), 32'h0);
        $display("test second reset done");
        stop_test();
    end

    // about twenty times the expected run length
    initial begin
        #100000;
        fail_count++;
        $display("CHECK FAILED at %0t got %h expected %h", $time, 32'h0, 32'h1);
        stop_test();
    end
endmodule
